// ==== verilog/acv_top.v ====
// Parallel output side of a 12-bit sampling converter with power-down and APB control
//
// Contract
// - Each result leaves as a 12-bit word on a bus that can float.
// - Bits and flag change on strobe fall, stable at strobe rise.
// - Format input high gives Gray code, low gives two's complement.
// - Gray code is offset by 2048; two's complement code is signed.
// - Sample bits float and return within 10 ns of power-down edges; the code takes two to three pclk (50-75 ns) after the edge.
// - Range flag floats and returns within 10 ns of power-down edges; the code takes two to three pclk (50-75 ns) after the edge.
// - Power-down low runs normally, high enters low-power mode.
// - Low-power mode floats sample bits, range flag and strobe.
// - Low-power mode stops all conversions until power-down returns low.
// - Reference select grounded disables internal reference, takes external nodes.
// - Range flag has the same 8.5 cycle delay as the sample word.
// - Range flag high when input exceeds reference span, low otherwise.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "acv_regs.vh"
module acv_top #(
   parameter W         = 12,
   parameter WAKE_CYC  = (`ACV_WAKE_MS * 1000000) / `ACV_CLK_NS
) (
   // APB slave
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   // Converter core
   input  wire          sample_clock_positive,
   input  wire [W-1:0]  core_result,
   input  wire          core_over,
   input  wire          core_under,
   input  wire          power_down_input,
   input  wire          format_select_input,
   input  wire          reference_select_input,
   output reg           core_enable,
   output reg           int_reference_enable,
   // Output pins
   output reg  [W-1:0]  sample_bits,
   output reg  [W-1:0]  sample_bits_oe,
   output reg           out_of_range_flag,
   output reg           out_of_range_flag_oe,
   output reg           data_valid_strobe,
   output reg           data_valid_strobe_oe,
   // Interrupt
   output reg           irq
);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Offset binary to reflected-binary Gray
   function [W-1:0] to_gray;
      input [W-1:0] ob;
      begin
         to_gray = ob ^ (ob >> 1);
      end
   endfunction

   // Decode of the implemented register offsets
   function is_mapped;
      input [11:0] a;
      begin
         case (a)
            `ACV_CTRL_ADDR,
            `ACV_STATUS_ADDR,
            `ACV_IRQ_STAT_ADDR,
            `ACV_IRQ_MASK_ADDR,
            `ACV_SAMPLE_ADDR,
            `ACV_WAKE_ADDR: is_mapped = 1'b1;
            default:        is_mapped = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   wire [4:0] sync_q;
   wire       sclk_s;
   wire       pd_pin_s;
   wire       gray_pin_s;
   wire       refgnd_s;
   wire       oor_s;

   acv_sync #(
      .W (5)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({sample_clock_positive, power_down_input, format_select_input,
               reference_select_input, core_over | core_under}),
      .q     (sync_q)
   );

   assign sclk_s     = sync_q[4];
   assign pd_pin_s   = sync_q[3];
   assign gray_pin_s = sync_q[2];
   assign refgnd_s   = ~sync_q[1];
   assign oor_s      = sync_q[0];

   ////////////////////////////////////////////////////////////////////////
   // Result alignment

   reg [W-1:0] res_d1_r;
   reg [W-1:0] res_d2_r;

   // Two stages, matching the range flag synchroniser,
   // so word and flag enter the pipeline from one conversion
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         res_d1_r <= {W{1'b0}};
         res_d2_r <= {W{1'b0}};
      end
      else
      begin
         res_d1_r <= core_result;
         res_d2_r <= res_d1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   reg [2:0]              ctrl_r;
   reg [`ACV_IRQ_W-1:0]   irq_stat_r;
   reg [`ACV_IRQ_W-1:0]   irq_mask_r;
   reg                    sclk_d_r;
   reg                    pd_d_r;
   reg [31:0]             wake_cnt_r;
   reg                    wake_busy_r;

   // Pin or software power-down
   wire pd_eff      = pd_pin_s | ctrl_r[`ACV_CTRL_PD_BIT];
   wire gray_eff    = gray_pin_s | ctrl_r[`ACV_CTRL_GRAY_BIT];
   // Internal reference off while the select pin is grounded or forced
   wire ref_int_nxt = ~pd_eff & ~refgnd_s & ~ctrl_r[`ACV_CTRL_REFX_BIT];
   // Edges of the synchronised sample clock
   wire sclk_rise   = sclk_s & ~sclk_d_r;
   wire sclk_fall   = ~sclk_s & sclk_d_r;
   wire link_step   = (sclk_rise | sclk_fall) & ~pd_eff;

   ////////////////////////////////////////////////////////////////////////
   // Conversion pipeline

   wire [W-1:0] coded;
   wire [W:0]   piped;

   // Core delivers offset binary; MSB flip yields two's complement
   assign coded = gray_eff ? to_gray(res_d2_r)
                           : {~res_d2_r[W-1], res_d2_r[W-2:0]};

   // Steps on both link clock edges, emptied in power-down
   acv_pipe #(
      .W     (W + 1),
      .DEPTH (`ACV_PIPE_HALF)
   ) u_pipe (
      .clk   (pclk),
      .rst_n (presetn),
      .step  (link_step),
      .flush (pd_eff),
      .din   ({oor_s, coded}),
      .dout  (piped)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output stage

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_d_r             <= 1'b0;
         pd_d_r               <= 1'b0;
         sample_bits          <= {W{1'b0}};
         sample_bits_oe       <= {W{1'b0}};
         out_of_range_flag    <= 1'b0;
         out_of_range_flag_oe <= 1'b0;
         data_valid_strobe    <= 1'b0;
         data_valid_strobe_oe <= 1'b0;
         core_enable          <= 1'b0;
         int_reference_enable <= 1'b0;
      end
      else
      begin
         sclk_d_r             <= sclk_s;
         pd_d_r               <= pd_eff;
         // One pclk (25 ns) after the synchronised level, both when floating and when driving
         sample_bits_oe       <= {W{~pd_eff}};
         out_of_range_flag_oe <= ~pd_eff;
         data_valid_strobe_oe <= ~pd_eff;
         core_enable          <= ~pd_eff;
         int_reference_enable <= ref_int_nxt;
         // Strobe is the inverted sample clock
         if (pd_eff)
            data_valid_strobe <= 1'b0;
         else
            data_valid_strobe <= ~sclk_s;
         // Data moves as the strobe falls, i.e. on sample clock rise
         if (sclk_rise & ~pd_eff)
         begin
            sample_bits       <= piped[W-1:0];
            out_of_range_flag <= piped[W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake timer

   // Counts the settling time after each wake
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_cnt_r  <= 32'h0000_0000;
         wake_busy_r <= 1'b0;
      end
      else if (pd_eff)
      begin
         wake_cnt_r  <= 32'h0000_0000;
         wake_busy_r <= 1'b0;
      end
      else if (pd_d_r)
      begin
         wake_cnt_r  <= WAKE_CYC[31:0];
         wake_busy_r <= 1'b1;
      end
      else if (wake_busy_r)
      begin
         wake_cnt_r  <= wake_cnt_r - 32'h0000_0001;
         wake_busy_r <= (wake_cnt_r > 32'h0000_0001);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB register file and interrupt

   wire       acc    = psel & penable & pready;
   wire       wr     = acc & pwrite;
   wire       rd_sel = psel & ~penable & ~pwrite;
   // Interrupt events
   wire       ev_range = sclk_rise & ~pd_eff & piped[W];
   wire       ev_pd_in = pd_eff & ~pd_d_r;
   wire       ev_woken = wake_busy_r & ~pd_eff & (wake_cnt_r == 32'h0000_0001);
   wire [2:0] ev       = {ev_woken, ev_pd_in, ev_range};
   wire       map_ok   = is_mapped(paddr);
   reg [31:0] rd_nxt;

   always @*
   begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `ACV_CTRL_ADDR:     rd_nxt = {29'h0, ctrl_r};
         `ACV_STATUS_ADDR:   rd_nxt = {26'h0, wake_busy_r, refgnd_s, gray_eff, gray_pin_s, pd_pin_s, pd_eff};
         `ACV_IRQ_STAT_ADDR: rd_nxt = {29'h0, irq_stat_r};
         `ACV_IRQ_MASK_ADDR: rd_nxt = {29'h0, irq_mask_r};
         `ACV_SAMPLE_ADDR:   rd_nxt = {19'h0, out_of_range_flag, sample_bits};
         `ACV_WAKE_ADDR:     rd_nxt = wake_cnt_r;
         default:            rd_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r     <= `ACV_CTRL_RST;
         irq_stat_r <= {`ACV_IRQ_W{1'b0}};
         irq_mask_r <= {`ACV_IRQ_W{1'b0}};
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         irq        <= 1'b0;
      end
      else
      begin
         // One wait state: ready in the second access cycle
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~map_ok;
         // Read data is taken in the setup cycle
         if (rd_sel)
            prdata <= rd_nxt;
         if (wr & (paddr == `ACV_CTRL_ADDR))
            ctrl_r <= pwdata[2:0];
         if (wr & (paddr == `ACV_IRQ_MASK_ADDR))
            irq_mask_r <= pwdata[`ACV_IRQ_W-1:0];
         // Set wins over write-one-to-clear
         if (wr & (paddr == `ACV_IRQ_STAT_ADDR))
            irq_stat_r <= (irq_stat_r & ~pwdata[`ACV_IRQ_W-1:0]) | ev;
         else
            irq_stat_r <= irq_stat_r | ev;
         // Level interrupt, a mask bit of one lets its flag through
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

endmodule // acv_top

// ==== pkg/acv_regs.vh ====
// Register map, field layout and timing constants of the converter output block
`ifndef ACV_REGS_VH
`define ACV_REGS_VH

// Register offsets (byte addresses)
`define ACV_CTRL_ADDR      12'h000
`define ACV_STATUS_ADDR    12'h004
`define ACV_IRQ_STAT_ADDR  12'h008
`define ACV_IRQ_MASK_ADDR  12'h00c
`define ACV_SAMPLE_ADDR    12'h010
`define ACV_WAKE_ADDR      12'h014

// Control fields
`define ACV_CTRL_PD_BIT    0
`define ACV_CTRL_GRAY_BIT  1
`define ACV_CTRL_REFX_BIT  2
`define ACV_CTRL_RST       3'h0

// Interrupt status fields
`define ACV_IRQ_W          3
`define ACV_IRQ_OOR_BIT    0
`define ACV_IRQ_PDN_BIT    1
`define ACV_IRQ_WAKE_BIT   2

// Timing
`define ACV_PD_FLOAT_NS    10
`define ACV_CLK_NS         25
`define ACV_WAKE_MS        10
`define ACV_PIPE_HALF      17

`endif

// ==== verilog/acv_sync.v ====
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module acv_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Levels
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end
      else
      begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;

endmodule // acv_sync

// ==== verilog/acv_pipe.v ====
// Half-cycle-step delay line for the sample word and range flag
`timescale 1ns/1ps
module acv_pipe #(
   parameter W     = 13,
   parameter DEPTH = 17
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Stream
   input  wire         step,
   input  wire         flush,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);

   reg [W-1:0] stage_r [0:DEPTH-1];
   integer     i;

   // Each step is one link clock edge, two steps a whole sample period
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            stage_r[i] <= {W{1'b0}};
      end
      else if (flush)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            stage_r[i] <= {W{1'b0}};
      end
      else if (step)
      begin
         stage_r[0] <= din;
         for (i = 1; i < DEPTH; i = i + 1)
            stage_r[i] <= stage_r[i-1];
      end
   end

   assign dout = stage_r[DEPTH-1];

endmodule // acv_pipe

// ==== dv/acv_top_checker.sv ====
// Assertions on the pins of the converter output block
`timescale 1ns/1ps
module acv_top_checker #(
   parameter W        = 12,
   parameter WAKE_CYC = 20
) (
   // APB
   input wire         pclk,
   input wire         presetn,
   input wire         psel,
   input wire         penable,
   input wire         pready,
   input wire         pslverr,
   // Core and pins
   input wire         power_down_input,
   input wire         reference_select_input,
   input wire         core_enable,
   input wire         int_reference_enable,
   input wire [W-1:0] sample_bits,
   input wire [W-1:0] sample_bits_oe,
   input wire         out_of_range_flag,
   input wire         out_of_range_flag_oe,
   input wire         data_valid_strobe,
   input wire         data_valid_strobe_oe
);
   wire pins_off = sample_bits_oe == 0 && !out_of_range_flag_oe && !data_valid_strobe_oe;
   wire pins_on  = &sample_bits_oe && out_of_range_flag_oe;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence pd_held;
      power_down_input [*4];
   endsequence
   sequence ref_low;
      !reference_select_input [*4];
   endsequence
   pd_float_a: assert property ($rose(power_down_input) |-> ##[1:4] pins_off)
      else $error("pins still driven after power-down");
   pd_wake_a: assert property ($fell(power_down_input) |-> ##[1:5] pins_on)
      else $error("pins not driven after wake");
   pd_off_a: assert property (pd_held |-> pins_off && !core_enable)
      else $error("core or pins active in power-down");
   bits_move_a: assert property ($changed(sample_bits) && pins_on && $past(out_of_range_flag_oe)
      |-> $fell(data_valid_strobe))
      else $error("sample bits moved off strobe fall");
   flag_move_a: assert property ($changed(out_of_range_flag) && pins_on && $past(out_of_range_flag_oe)
      |-> $fell(data_valid_strobe))
      else $error("range flag moved off strobe fall");
   oe_group_a: assert property (sample_bits_oe == {W{out_of_range_flag_oe}})
      else $error("output enables disagree");
   apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("apb wait state wrong");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   ref_gnd_a: assert property (ref_low |-> !int_reference_enable)
      else $error("internal reference on while grounded");
   ref_core_a: assert property (int_reference_enable |-> core_enable)
      else $error("reference on with core off");
endmodule // acv_top_checker

bind acv_top acv_top_checker #(.W(W), .WAKE_CYC(WAKE_CYC)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .power_down_input(power_down_input), .core_enable(core_enable),
   .reference_select_input(reference_select_input), .int_reference_enable(int_reference_enable),
   .sample_bits(sample_bits), .sample_bits_oe(sample_bits_oe), .out_of_range_flag(out_of_range_flag),
   .out_of_range_flag_oe(out_of_range_flag_oe), .data_valid_strobe(data_valid_strobe),
   .data_valid_strobe_oe(data_valid_strobe_oe));

// ==== dv/acv_capture.sv ====
// Capture logic latching words on the strobe's rising edge
`timescale 1ns/1ps
module acv_capture #(
   parameter W = 12
) (
   // Pins
   input wire         strobe,
   input wire         strobe_oe,
   input wire [W-1:0] bits,
   input wire [W-1:0] bits_oe,
   input wire         flag,
   input wire         flag_oe,
   // Captured
   output reg [W:0]   word,
   output int         cnt
);
   initial cnt = 0;
   always @(posedge strobe)
      // Floating lines carry nothing
      if (strobe_oe && bits_oe[0] && flag_oe)
      begin
         word <= {flag, bits};
         cnt  <= cnt + 1;
      end
endmodule // acv_capture

// ==== dv/test_acv_top.sv ====
// Self-checking bench for the converter output block
`timescale 1ns/1ps
`include "acv_regs.vh"
module test_acv_top;
   localparam W = 12;
   localparam WAKE = 20;
   reg          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg  [11:0]  paddr = 0;
   reg  [31:0]  pwdata = 0, seed = 87949, rd;
   wire [31:0]  prdata;
   wire         pready, pslverr, cen, iref, flag, flag_oe, strb, strb_oe, irq;
   wire [W-1:0] bits, bits_oe;
   reg          sclk = 0, over = 0, under = 0, pd = 0, fmt = 0, refsel = 1, err, g;
   reg  [W-1:0] res = 0;
   wire [W:0]   word;
   int          cnt, c0, error_cnt = 0, n_tests = 0;

   acv_top #(.W(W), .WAKE_CYC(WAKE)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_clock_positive(sclk), .core_result(res), .core_over(over), .core_under(under),
      .power_down_input(pd), .format_select_input(fmt), .reference_select_input(refsel),
      .core_enable(cen), .int_reference_enable(iref), .sample_bits(bits), .sample_bits_oe(bits_oe),
      .out_of_range_flag(flag), .out_of_range_flag_oe(flag_oe), .data_valid_strobe(strb),
      .data_valid_strobe_oe(strb_oe), .irq(irq));
   acv_capture #(.W(W)) cap (.strobe(strb), .strobe_oe(strb_oe), .bits(bits), .bits_oe(bits_oe),
      .flag(flag), .flag_oe(flag_oe), .word(word), .cnt(cnt));

   initial forever #12.5 pclk = ~pclk;
   initial
   begin
      #7;
      forever #100 sclk = ~sclk;
   end
   //////////////////////////////////////////////////////////////
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   function [W-1:0] enc(input [W-1:0] ob, input gr);
      enc = gr ? ob ^ (ob >> 1) : ob ^ 12'h800;
   endfunction
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      error_cnt++;
      summarize;
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, `ACV_CTRL_ADDR, 0);
      chk("ctrl reset", 0, rd);
      apb(0, 12'h040, 0);
      chk("unmapped error", 1, err);
      chk("unmapped data", 0, rd);
      apb(1, `ACV_IRQ_MASK_ADDR, 32'h1);
      $display("test registers done");
      pd <= 1;
      repeat (5) @(posedge pclk);
      c0 = cnt;
      chk("pins in power-down", 0, {bits_oe, flag_oe, strb_oe, cen});
      repeat (100) @(posedge pclk);
      chk("captures in power-down", c0, cnt);
      pd <= 0;
      repeat (6) @(posedge pclk);
      chk("pins after wake", 15'h7fff, {bits_oe, flag_oe, strb_oe, cen});
      refsel <= 0;
      repeat (6) @(posedge pclk);
      chk("reference grounded", 0, iref);
      refsel <= 1;
      repeat (6) @(posedge pclk);
      chk("reference internal", 1, iref);
      apb(1, `ACV_CTRL_ADDR, 32'h4);
      repeat (2) @(posedge pclk);
      chk("reference forced external", 0, iref);
      apb(1, `ACV_CTRL_ADDR, 32'h1);
      repeat (2) @(posedge pclk);
      chk("pins in soft power-down", 0, {bits_oe, flag_oe, strb_oe, cen});
      apb(1, `ACV_CTRL_ADDR, 32'h0);
      apb(0, `ACV_WAKE_ADDR, 0);
      chk("wake count", WAKE, rd);
      apb(0, `ACV_STATUS_ADDR, 0);
      chk("status while waking", 32'h20, rd);
      $display("test power-down done");
      for (int i = 0; i < 10; i++)
      begin
         seed = xs(seed);
         res <= (i < 2) ? {W{i[0]}} : seed[W-1:0];
         fmt <= seed[12];
         over <= (i == 1) || (seed[15:13] == 0);
         under <= (i == 0);
         apb(1, `ACV_CTRL_ADDR, {30'h0, seed[16], 1'b0});
         g = fmt | seed[16];
         repeat (100) @(posedge pclk);
         chk("captured word", {over | under, enc(res, g)}, word);
         apb(0, `ACV_SAMPLE_ADDR, 0);
         chk("sample register", {over | under, enc(res, g)}, rd);
      end
      $display("test words done");
      over <= 0;
      under <= 0;
      repeat (100) @(posedge pclk);
      apb(0, `ACV_IRQ_STAT_ADDR, 0);
      chk("range event", 1, rd[0]);
      chk("event flags", 32'h7, rd);
      repeat (2) @(posedge pclk);
      chk("irq raised", 1, irq);
      apb(1, `ACV_IRQ_MASK_ADDR, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 0, irq);
      apb(1, `ACV_IRQ_MASK_ADDR, 32'h1);
      apb(1, `ACV_IRQ_STAT_ADDR, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 0, irq);
      apb(1, `ACV_IRQ_MASK_ADDR, 32'h6);
      repeat (2) @(posedge pclk);
      chk("irq power events", 1, irq);
      apb(1, `ACV_IRQ_STAT_ADDR, 32'h7);
      apb(0, `ACV_IRQ_STAT_ADDR, 0);
      chk("flags cleared", 0, rd);
      $display("test interrupt done");
      summarize;
   end
endmodule // test_acv_top
